// ==== src/tri_fifo_pkg.sv ====
// How it works
// - Port A writes A-to-B, reads C-to-A, 36 bits.
// - Port A almost-empty low at C-to-A count <= offset.
// - Port B almost-empty low at A-to-B count <= offset.
// - Port A almost-full low when A-to-B free <= offset.
// - Port C almost-full low when C-to-A free <= offset.
// - Port B outputs 18-bit halves of A-to-B words.
// - Port C accepts 18-bit halves into C-to-A words.
// - Pin high at reset: most significant half first.
// - Pin low at reset: least significant half first.
// - After reset pin high standard, low fall-through.
// - Fall-through: first word appears without a read.
// - Offset selects at reset: 8, 16, 64 or programmed.
package tri_fifo_pkg;
    // Queue geometry: a full port A word and its two halves.
    localparam int DATA_W = 36;
    localparam int HALF_W = 18;
    localparam int QUEUE_AW = 10;
    localparam int OFFS_W = QUEUE_AW + 1;
    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int BUS_W = 32;
    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADR_AE_OFF_A = 8'h00;
    localparam logic [ADDR_W-1:0] ADR_AE_OFF_B = 8'h04;
    localparam logic [ADDR_W-1:0] ADR_AF_OFF_A = 8'h08;
    localparam logic [ADDR_W-1:0] ADR_AF_OFF_C = 8'h0c;
    localparam logic [ADDR_W-1:0] ADR_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADR_LEVEL_AB = 8'h14;
    localparam logic [ADDR_W-1:0] ADR_LEVEL_CA = 8'h18;
    // Status register bit positions.
    localparam int ST_BIG = 0;
    localparam int ST_FALL_THROUGH_MODE = 1;
    localparam int ST_SEL_LO = 2;
    localparam int ST_SEL_HI = 3;
    // Offset select codes sampled during reset.
    localparam logic [1:0] FS_PROGRAM = 2'h0;
    localparam logic [1:0] FS_DEF_8 = 2'h1;
    localparam logic [1:0] FS_DEF_16 = 2'h2;
    localparam logic [1:0] FS_DEF_64 = 2'h3;
    // Default thresholds and the reset value of programmed offsets.
    localparam int DEF_OFF_8 = 32'h0000_0008;
    localparam int DEF_OFF_16 = 32'h0000_0010;
    localparam int DEF_OFF_64 = 32'h0000_0040;
    localparam int PROG_OFF_RESET = 32'h0000_0008;
    // Write and read responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== src/tri_fifo_queue.sv ====
`timescale 1ns/1ps
// One-clock queue with a prefetched output word register.
module tri_fifo_queue #(
    parameter int WIDTH = 36,
    parameter int AW = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [WIDTH-1:0] wr_data,
    output logic in_ready,
    input wire logic rd_en,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    output logic [AW:0] level,
    output logic [AW:0] free
);
    localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

    logic [WIDTH-1:0] mem_r [0:(1<<AW)-1]; // Word storage.
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt; // Next slot to fill.
    logic [AW-1:0] rd_ptr_r, rd_ptr_nxt; // Next slot to prefetch.
    logic [AW:0] cnt_r, cnt_nxt; // Words held in storage.
    logic valid_r, valid_nxt; // Output register holds a word.
    logic [WIDTH-1:0] data_r, data_nxt; // Output word.
    logic push, load, pop;

    // Storage refuses only when every slot is taken.
    assign in_ready = cnt_r != DEPTH;
    assign out_valid = valid_r;
    assign out_data = data_r;
    assign level = cnt_r + (AW+1)'(valid_r);
    assign free = DEPTH + (AW+1)'(1) - level;

    // Next state: prefetch whenever the output register empties.
    always_comb begin
        push = wr_en && in_ready;
        pop = rd_en && valid_r;
        load = (cnt_r != '0) && (!valid_r || rd_en);
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = load ? rd_ptr_r + 1'b1 : rd_ptr_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(load);
        valid_nxt = load ? 1'b1 : (pop ? 1'b0 : valid_r);
        data_nxt = load ? mem_r[rd_ptr_r] : data_r;
    end

    // Registers; storage itself needs no reset.
    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r <= '0;
            valid_r <= 1'b0;
            data_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r <= cnt_nxt;
            valid_r <= valid_nxt;
            data_r <= data_nxt;
        end
        if (push) begin
            mem_r[wr_ptr_r] <= wr_data;
        end
    end

    // A write without a read raises the level by exactly one.
    property p_level_up;
        @(posedge clk) disable iff (rst)
        (push && !pop) |=> level == $past(level) + 1'b1;
    endproperty
    a_level_up: assert property (p_level_up)
        else $error("Queue level did not grow on a write.");
endmodule

// ==== src/tri_fifo_top.sv ====
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Three-port queue pair with almost flags and a register slave.
module tri_fifo_top #(
    parameter int AW = tri_fifo_pkg::QUEUE_AW
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic BYTE_ORDER_OR_TIMING_SELECT,
    input wire logic DEFAULT_OFFSET_SELECT_0,
    input wire logic DEFAULT_OFFSET_SELECT_1,
    input wire logic A_ENABLE,
    input wire logic A_WRITE,
    input wire logic [tri_fifo_pkg::DATA_W-1:0] A_DATA_IN,
    output logic [tri_fifo_pkg::DATA_W-1:0] A_DATA_OUT,
    output logic A_DATA_OE_N,
    output logic A_INPUT_READY,
    output logic A_OUTPUT_READY,
    input wire logic B_ENABLE,
    output logic [tri_fifo_pkg::HALF_W-1:0] B_DATA,
    output logic B_OUTPUT_READY,
    input wire logic C_ENABLE,
    input wire logic [tri_fifo_pkg::HALF_W-1:0] C_DATA,
    output logic C_INPUT_READY,
    output logic ALMOST_EMPTY_FLAG_PORT_A_N,
    output logic ALMOST_EMPTY_FLAG_PORT_B_N,
    output logic ALMOST_FULL_FLAG_PORT_A_N,
    output logic ALMOST_FULL_FLAG_PORT_C_N,
    input wire logic [tri_fifo_pkg::ADDR_W-1:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [tri_fifo_pkg::BUS_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [tri_fifo_pkg::ADDR_W-1:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [tri_fifo_pkg::BUS_W-1:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    import tri_fifo_pkg::*;

    // Returns true when a count sits at or below its threshold.
    function automatic logic at_or_below(input logic [AW:0] v,
                                         input logic [AW:0] lim);
        return v <= lim;
    endfunction

    // Picks the threshold in force for a given offset select.
    function automatic logic [AW:0] eff_offset(input logic [1:0] sel,
                                               input logic [AW:0] prog);
        int v;
        unique case (sel)
            FS_DEF_8: v = DEF_OFF_8;
            FS_DEF_16: v = DEF_OFF_16;
            FS_DEF_64: v = DEF_OFF_64;
            FS_PROGRAM: v = int'(prog);
        endcase
        // A default beyond a small queue saturates rather than wrapping.
        return ((v >> (AW+1)) != 0) ? '1 : (AW+1)'(v);
    endfunction

    // Picks the half of a word that leaves first or second.
    function automatic logic [HALF_W-1:0] pick_half(
        input logic [DATA_W-1:0] w, input logic first, input logic big);
        return (first == big) ? w[DATA_W-1:HALF_W] : w[HALF_W-1:0];
    endfunction

    // Merges a bus write into a register under its byte strobes.
    function automatic logic [BUS_W-1:0] merge(input logic [BUS_W-1:0] old,
                                              input logic [BUS_W-1:0] d,
                                              input logic [3:0] strb);
        logic [BUS_W-1:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pins pass two flip-flops before anything reads them.
    logic [2:0] pins_s1_r, pins_s2_r;
    always_ff @(posedge REF_CLK) begin
        pins_s1_r <= {DEFAULT_OFFSET_SELECT_1, DEFAULT_OFFSET_SELECT_0,
                      BYTE_ORDER_OR_TIMING_SELECT};
        pins_s2_r <= pins_s1_r;
    end

    // Byte order and offset select caught during reset and kept; timing mode stays live.
    logic big_r, big_nxt; // Big-endian ordering.
    logic [1:0] sel_r, sel_nxt; // Offset select.
    logic fall_through_mode; // Live timing mode after reset.
    always_comb begin
        big_nxt = RESET ? pins_s2_r[0] : big_r;
        sel_nxt = RESET ? pins_s2_r[2:1] : sel_r;
    end
    always_ff @(posedge REF_CLK) begin
        big_r <= big_nxt;
        sel_r <= sel_nxt;
    end
    // A low pin selects fall-through, a high pin standard mode.
    assign fall_through_mode = !pins_s2_r[0];

    // Queue wiring.
    logic ab_in_ready, ab_valid, ab_pop, a_wr;
    logic ca_in_ready, ca_valid, ca_push, a_rd;
    logic [DATA_W-1:0] ab_data, ca_data, ca_wr_data;
    logic [AW:0] ab_level, ab_free, ca_level, ca_free;

    // The A-to-B queue: filled from port A, drained by port B.
    tri_fifo_queue #(.WIDTH(DATA_W), .AW(AW)) a_to_b_queue (
        .clk(REF_CLK), .rst(RESET),
        .wr_en(a_wr), .wr_data(A_DATA_IN), .in_ready(ab_in_ready),
        .rd_en(ab_pop), .out_valid(ab_valid), .out_data(ab_data),
        .level(ab_level), .free(ab_free));

    // The C-to-A queue: filled from port C, drained by port A.
    tri_fifo_queue #(.WIDTH(DATA_W), .AW(AW)) c_to_a_queue (
        .clk(REF_CLK), .rst(RESET),
        .wr_en(ca_push), .wr_data(ca_wr_data), .in_ready(ca_in_ready),
        .rd_en(a_rd), .out_valid(ca_valid), .out_data(ca_data),
        .level(ca_level), .free(ca_free));

    // Port state.
    logic [DATA_W-1:0] a_hold_r, a_hold_nxt; // Standard-mode A word.
    logic half_b_r, half_b_nxt; // Second half of B word next.
    logic [HALF_W-1:0] b_hold_r, b_hold_nxt; // Standard-mode B half.
    logic b_rd;
    logic half_c_r, half_c_nxt; // Second half of C word next.
    logic [HALF_W-1:0] c_first_r, c_first_nxt; // First C half.
    logic c_wr;

    // Port handshakes; port A drives its pins whenever A_WRITE is low.
    assign a_wr = A_ENABLE && A_WRITE && ab_in_ready;
    assign a_rd = A_ENABLE && !A_WRITE && ca_valid;
    assign b_rd = B_ENABLE && ab_valid;
    assign ab_pop = b_rd && half_b_r;
    assign c_wr = C_ENABLE && ca_in_ready;
    assign ca_push = c_wr && half_c_r;
    assign A_DATA_OE_N = A_WRITE;
    assign A_INPUT_READY = ab_in_ready;
    assign A_OUTPUT_READY = ca_valid;
    assign B_OUTPUT_READY = ab_valid;
    assign C_INPUT_READY = ca_in_ready;
    // Fall-through shows the waiting word; standard shows the last read.
    assign A_DATA_OUT = fall_through_mode ? ca_data : a_hold_r;
    assign B_DATA = fall_through_mode ?
                    pick_half(ab_data, !half_b_r, big_r) : b_hold_r;
    // The first C half lands in the upper half when big-endian.
    assign ca_wr_data = big_r ? {c_first_r, C_DATA}
                              : {C_DATA, c_first_r};

    // Next state of the three ports.
    always_comb begin
        a_hold_nxt = a_rd ? ca_data : a_hold_r;
        half_b_nxt = b_rd ? !half_b_r : half_b_r;
        b_hold_nxt = b_rd ? pick_half(ab_data, !half_b_r, big_r)
                          : b_hold_r;
        half_c_nxt = c_wr ? !half_c_r : half_c_r;
        c_first_nxt = (c_wr && !half_c_r) ? C_DATA : c_first_r;
    end
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            a_hold_r <= '0;
            half_b_r <= 1'b0;
            b_hold_r <= '0;
            half_c_r <= 1'b0;
            c_first_r <= '0;
        end else begin
            a_hold_r <= a_hold_nxt;
            half_b_r <= half_b_nxt;
            b_hold_r <= b_hold_nxt;
            half_c_r <= half_c_nxt;
            c_first_r <= c_first_nxt;
        end
    end

    // Programmed offsets and the thresholds in force.
    logic [AW:0] ae_off_a_r, ae_off_b_r, af_off_a_r, af_off_c_r;
    logic [AW:0] ae_off_a_nxt, ae_off_b_nxt, af_off_a_nxt, af_off_c_nxt;
    logic [AW:0] ae_a_eff, ae_b_eff, af_a_eff, af_c_eff;
    assign ae_a_eff = eff_offset(sel_r, ae_off_a_r);
    assign ae_b_eff = eff_offset(sel_r, ae_off_b_r);
    assign af_a_eff = eff_offset(sel_r, af_off_a_r);
    assign af_c_eff = eff_offset(sel_r, af_off_c_r);

    // Flags are registered, low while their condition holds.
    logic [3:0] flags_r, flags_nxt; // AE_A, AE_B, AF_A, AF_C.
    always_comb begin
        flags_nxt[0] = !at_or_below(ca_level, ae_a_eff);
        flags_nxt[1] = !at_or_below(ab_level, ae_b_eff);
        flags_nxt[2] = !at_or_below(ab_free, af_a_eff);
        flags_nxt[3] = !at_or_below(ca_free, af_c_eff);
    end
    always_ff @(posedge REF_CLK) begin
        flags_r <= RESET ? 4'hc : flags_nxt;
    end
    assign ALMOST_EMPTY_FLAG_PORT_A_N = flags_r[0];
    assign ALMOST_EMPTY_FLAG_PORT_B_N = flags_r[1];
    assign ALMOST_FULL_FLAG_PORT_A_N = flags_r[2];
    assign ALMOST_FULL_FLAG_PORT_C_N = flags_r[3];

    // Register slave write side: address and data in either order.
    logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
    logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
    logic [BUS_W-1:0] wdata_r, wdata_nxt;
    logic [3:0] wstrb_r, wstrb_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    assign AWREADY = !aw_got_r && !bvalid_r;
    assign WREADY = !w_got_r && !bvalid_r;
    assign BVALID = bvalid_r;
    assign BRESP = bresp_r;
    always_comb begin
        aw_got_nxt = aw_got_r || (AWVALID && AWREADY);
        awaddr_nxt = (AWVALID && AWREADY) ? AWADDR : awaddr_r;
        w_got_nxt = w_got_r || (WVALID && WREADY);
        wdata_nxt = (WVALID && WREADY) ? WDATA : wdata_r;
        wstrb_nxt = (WVALID && WREADY) ? WSTRB : wstrb_r;
        bvalid_nxt = bvalid_r && !BREADY;
        bresp_nxt = bresp_r;
        ae_off_a_nxt = ae_off_a_r;
        ae_off_b_nxt = ae_off_b_r;
        af_off_a_nxt = af_off_a_r;
        af_off_c_nxt = af_off_c_r;
        // Commit once both halves of the write are held.
        if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
            aw_got_nxt = 1'b0;
            w_got_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = RESP_OKAY;
            unique case (awaddr_nxt)
                ADR_AE_OFF_A: ae_off_a_nxt = (AW+1)'(merge(
                    BUS_W'(ae_off_a_r), wdata_nxt, wstrb_nxt));
                ADR_AE_OFF_B: ae_off_b_nxt = (AW+1)'(merge(
                    BUS_W'(ae_off_b_r), wdata_nxt, wstrb_nxt));
                ADR_AF_OFF_A: af_off_a_nxt = (AW+1)'(merge(
                    BUS_W'(af_off_a_r), wdata_nxt, wstrb_nxt));
                ADR_AF_OFF_C: af_off_c_nxt = (AW+1)'(merge(
                    BUS_W'(af_off_c_r), wdata_nxt, wstrb_nxt));
                ADR_STATUS, ADR_LEVEL_AB, ADR_LEVEL_CA: begin
                    bresp_nxt = RESP_OKAY;
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // Register slave read side: one read answered at a time.
    logic rvalid_r, rvalid_nxt;
    logic [BUS_W-1:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    assign ARREADY = !rvalid_r;
    assign RVALID = rvalid_r;
    assign RDATA = rdata_r;
    assign RRESP = rresp_r;
    always_comb begin
        rvalid_nxt = rvalid_r && !RREADY;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (ARVALID && ARREADY) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = RESP_OKAY;
            rdata_nxt = '0;
            unique case (ARADDR)
                ADR_AE_OFF_A: rdata_nxt = BUS_W'(ae_off_a_r);
                ADR_AE_OFF_B: rdata_nxt = BUS_W'(ae_off_b_r);
                ADR_AF_OFF_A: rdata_nxt = BUS_W'(af_off_a_r);
                ADR_AF_OFF_C: rdata_nxt = BUS_W'(af_off_c_r);
                ADR_STATUS: begin
                    rdata_nxt[ST_BIG] = big_r;
                    rdata_nxt[ST_FALL_THROUGH_MODE] = fall_through_mode;
                    rdata_nxt[ST_SEL_HI:ST_SEL_LO] = sel_r;
                end
                ADR_LEVEL_AB: rdata_nxt = BUS_W'(ab_level);
                ADR_LEVEL_CA: rdata_nxt = BUS_W'(ca_level);
                default: begin
                    rresp_nxt = RESP_SLVERR;
                end
            endcase
        end
    end

    // Bus slave registers.
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= RESP_OKAY;
            ae_off_a_r <= (AW+1)'(PROG_OFF_RESET);
            ae_off_b_r <= (AW+1)'(PROG_OFF_RESET);
            af_off_a_r <= (AW+1)'(PROG_OFF_RESET);
            af_off_c_r <= (AW+1)'(PROG_OFF_RESET);
        end else begin
            aw_got_r <= aw_got_nxt;
            w_got_r <= w_got_nxt;
            awaddr_r <= awaddr_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            ae_off_a_r <= ae_off_a_nxt;
            ae_off_b_r <= ae_off_b_nxt;
            af_off_a_r <= af_off_a_nxt;
            af_off_c_r <= af_off_c_nxt;
        end
    end

    // Checks on the port behaviour.
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    sequence s_c_first;
        c_wr && !half_c_r;
    endsequence
    sequence s_b_first;
        b_rd && !half_b_r;
    endsequence

    property p_ae_a;
        ca_level > ae_a_eff |=> ALMOST_EMPTY_FLAG_PORT_A_N;
    endproperty
    a_ae_a: assert property (p_ae_a)
        else $error("Port A almost-empty low above its offset.");
    property p_ae_b;
        ab_level <= ae_b_eff |=> !ALMOST_EMPTY_FLAG_PORT_B_N;
    endproperty
    a_ae_b: assert property (p_ae_b)
        else $error("Port B almost-empty high at its offset.");
    property p_af_a;
        ab_free <= af_a_eff |=> !ALMOST_FULL_FLAG_PORT_A_N;
    endproperty
    a_af_a: assert property (p_af_a)
        else $error("Port A almost-full high at its offset.");
    property p_af_c;
        ca_free > af_c_eff |=> ALMOST_FULL_FLAG_PORT_C_N;
    endproperty
    a_af_c: assert property (p_af_c)
        else $error("Port C almost-full low above its offset.");
    property p_c_pair;
        s_c_first ##1 c_wr |-> ca_wr_data == (big_r ?
            {$past(C_DATA), C_DATA} : {C_DATA, $past(C_DATA)});
    endproperty
    a_c_pair: assert property (p_c_pair)
        else $error("Port C halves paired in the wrong order.");
    property p_b_pop;
        s_b_first ##1 b_rd |-> ab_pop ##1 !half_b_r;
    endproperty
    a_b_pop: assert property (p_b_pop)
        else $error("Port B word not consumed after two halves.");
    property p_fall_through;
        fall_through_mode && ca_level == '0 && ca_push
            |-> ##[1:2] A_OUTPUT_READY;
    endproperty
    a_fall_through: assert property (p_fall_through)
        else $error("First word did not fall through to port A.");
    property p_order_kept;
        1 |=> $stable(big_r) && $stable(sel_r);
    endproperty
    a_order_kept: assert property (p_order_kept)
        else $error("Reset configuration changed outside reset.");
    property p_default_64;
        sel_r == FS_DEF_64 && ab_level <= DEF_OFF_64
            |=> !ALMOST_EMPTY_FLAG_PORT_B_N;
    endproperty
    a_default_64: assert property (p_default_64)
        else $error("Default offset of 64 not in force.");
endmodule

// ==== test/tri_fifo_c_source.sv ====
`timescale 1ns/1ps
// Port C writer: sends one word as two halves, each held until taken.
module tri_fifo_c_source (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic big,
    input wire logic [35:0] word,
    input wire logic ready,
    output logic en,
    output logic [17:0] data
);
    logic [1:0] left_r; // Halves still to send.
    // Count halves down only at edges where the device takes one.
    always_ff @(posedge clk) begin
        if (rst) begin
            left_r <= 2'h0;
        end else if (start) begin
            left_r <= 2'h2;
        end else if (en && ready) begin
            left_r <= left_r - 2'h1;
        end
    end
    assign en = (left_r != 2'h0);
    // Half order follows byte order; idle lines show inverted data.
    assign data = !en ? ~word[17:0] : (left_r[1] ^ big) ? word[17:0]
                : word[35:18];
endmodule

// ==== test/tri_port_fifo_flags_and_mode_tb.sv ====
`timescale 1ns/1ps
module tri_port_fifo_flags_and_mode_tb;
    import tri_fifo_pkg::*;
    logic REF_CLK = 0, RESET = 1, BYTE_ORDER_OR_TIMING_SELECT = 1;
    logic DEFAULT_OFFSET_SELECT_0 = 0, DEFAULT_OFFSET_SELECT_1 = 0;
    logic A_ENABLE = 0, A_WRITE = 1, B_ENABLE = 0, C_ENABLE, go = 0;
    logic A_DATA_OE_N, A_INPUT_READY, A_OUTPUT_READY, B_OUTPUT_READY;
    logic C_INPUT_READY, ALMOST_EMPTY_FLAG_PORT_A_N;
    logic ALMOST_EMPTY_FLAG_PORT_B_N, ALMOST_FULL_FLAG_PORT_A_N;
    logic ALMOST_FULL_FLAG_PORT_C_N, AWREADY, WREADY, BVALID, ARREADY;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic RVALID;
    logic [1:0] BRESP, RRESP;
    logic [ADDR_W-1:0] AWADDR = 8'h00, ARADDR = 8'h00;
    logic [BUS_W-1:0] WDATA = 32'h0, RDATA, q;
    logic [DATA_W-1:0] A_DATA_IN = 36'h0, A_DATA_OUT, cw = 36'h0;
    logic [HALF_W-1:0] B_DATA, C_DATA;
    int err_total = 0, check_count = 0;
    always #2 REF_CLK = ~REF_CLK;
    tri_fifo_top #(.AW(3)) i_tri_fifo_top (.REF_CLK, .RESET,
        .BYTE_ORDER_OR_TIMING_SELECT, .DEFAULT_OFFSET_SELECT_0,
        .DEFAULT_OFFSET_SELECT_1, .A_ENABLE, .A_WRITE, .A_DATA_IN,
        .A_DATA_OUT, .A_DATA_OE_N, .A_INPUT_READY, .A_OUTPUT_READY,
        .B_ENABLE, .B_DATA, .B_OUTPUT_READY, .C_ENABLE, .C_DATA,
        .C_INPUT_READY, .ALMOST_EMPTY_FLAG_PORT_A_N,
        .ALMOST_EMPTY_FLAG_PORT_B_N, .ALMOST_FULL_FLAG_PORT_A_N,
        .ALMOST_FULL_FLAG_PORT_C_N, .AWADDR, .AWVALID, .AWREADY, .WDATA,
        .WSTRB(4'hf), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
        .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY);
    tri_fifo_c_source i_tri_fifo_c_source (.clk(REF_CLK), .rst(RESET),
        .start(go), .big(BYTE_ORDER_OR_TIMING_SELECT), .word(cw),
        .ready(C_INPUT_READY), .en(C_ENABLE), .data(C_DATA));
    // Prints the counts and the verdict, then stops the run.
    task automatic final_report();
        $display("checks=%0d bad=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Compares one value and counts it.
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    function automatic logic [35:0] wd(input int k);
        return {18'(k + 256), 18'(k)};
    endfunction
    // Master reset with the pins set first and left steady afterwards.
    task automatic rst(input logic pin, input logic [1:0] fs);
        BYTE_ORDER_OR_TIMING_SELECT <= pin;
        {DEFAULT_OFFSET_SELECT_1, DEFAULT_OFFSET_SELECT_0} <= fs;
        RESET <= 1;
        repeat (4) @(posedge REF_CLK);
        RESET <= 0;
        @(posedge REF_CLK);
    endtask
    // One bus write (wr high) or read into q; r gets the response.
    task automatic axi(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [1:0] r);
        logic aw, w, ar, v;
        int n;
        AWADDR <= a;
        ARADDR <= a;
        WDATA <= d;
        AWVALID <= wr;
        WVALID <= wr;
        BREADY <= wr;
        ARVALID <= !wr;
        RREADY <= !wr;
        for (n = 0; n < 40; n++) begin
            @(negedge REF_CLK);
            aw = AWVALID && AWREADY;
            w = WVALID && WREADY;
            ar = ARVALID && ARREADY;
            v = wr ? BVALID : RVALID;
            r = wr ? BRESP : RRESP;
            q = RDATA;
            @(posedge REF_CLK);
            if (aw) AWVALID <= 0;
            if (w) WVALID <= 0;
            if (ar) ARVALID <= 0;
            if (v) break;
        end
        BREADY <= 0;
        RREADY <= 0;
        @(posedge REF_CLK);
        if (n == 40) err_total++;
        if (n == 40) final_report();
    endtask
    // Port handshake: p 0 writes A, p 1 reads A, p 2 reads B.
    task automatic xfer(input int p, input logic [35:0] w);
        logic rdy;
        int n;
        A_WRITE <= (p == 0);
        A_DATA_IN <= w;
        A_ENABLE <= (p < 2);
        B_ENABLE <= (p == 2);
        for (n = 0; n < 40; n++) begin
            @(negedge REF_CLK);
            rdy = p == 0 ? A_INPUT_READY : A_OUTPUT_READY;
            rdy = p == 2 ? B_OUTPUT_READY : rdy;
            @(posedge REF_CLK);
            if (rdy === 1'b1) break;
        end
        A_ENABLE <= 0;
        B_ENABLE <= 0;
        A_WRITE <= 1;
        A_DATA_IN <= ~w;
        if (n == 40) err_total++;
        if (n == 40) final_report();
    endtask
    task automatic rdb(input logic [17:0] exp);
        xfer(2, 36'h0);
        @(negedge REF_CLK);
        chk(36'(B_DATA), 36'(exp));
        @(posedge REF_CLK);
    endtask
    // Sets all four offsets to 2 and reads one back.
    task automatic prog();
        logic [1:0] r;
        for (int i = 0; i < 4; i++) begin
            axi(1, 8'(4 * i), 32'h2, r);
            chk(36'(r), 36'(RESP_OKAY));
        end
        axi(0, ADR_AF_OFF_C, 32'h0, r);
        chk(36'(q), 36'h2);
    endtask
    task automatic t_cfg();
        logic [1:0] r;
        for (int fs = 1; fs < 4; fs++) begin
            rst(1'b1, 2'(fs));
            axi(0, ADR_STATUS, 32'h0, r);
            chk(36'(q[3:0]), 36'({2'(fs), 2'b01}));
        end
        axi(0, 8'h40, 32'h0, r);
        chk(36'(r), 36'(RESP_SLVERR));
        axi(1, 8'h40, 32'h1, r);
        chk(36'(r), 36'(RESP_SLVERR));
        $display("t_cfg end");
    endtask
    // Standard big-endian A to B: fill until refused, then drain.
    task automatic t_ab();
        rst(1'b1, 2'h0);
        prog();
        for (int k = 1; k < 10; k++) begin
            xfer(0, wd(k));
            repeat (3) @(negedge REF_CLK);
            chk(36'(ALMOST_EMPTY_FLAG_PORT_B_N), 36'(k > 2));
            chk(36'(ALMOST_FULL_FLAG_PORT_A_N), 36'(k < 7));
            chk(36'(A_INPUT_READY), 36'(k < 9));
            @(posedge REF_CLK);
        end
        for (int k = 1; k < 10; k++) begin
            rdb(18'(k + 256));
            rdb(18'(k));
        end
        // Standard mode: a C word waits unseen until port A reads it.
        cw <= wd(3);
        go <= 1;
        @(posedge REF_CLK);
        go <= 0;
        repeat (6) @(negedge REF_CLK);
        chk(A_DATA_OUT, 36'h0);
        chk(36'(A_DATA_OE_N), 36'h1);
        @(posedge REF_CLK);
        xfer(1, 36'h0);
        @(negedge REF_CLK);
        chk(A_DATA_OUT, wd(3));
        @(posedge REF_CLK);
        $display("t_ab end");
    endtask
    // Fall-through little-endian: C to A flags and data, then A to B.
    task automatic t_ft();
        rst(1'b0, 2'h0);
        prog();
        for (int k = 1; k < 10; k++) begin
            cw <= wd(k);
            go <= 1;
            @(posedge REF_CLK);
            go <= 0;
            repeat (8) @(negedge REF_CLK);
            chk(36'(ALMOST_EMPTY_FLAG_PORT_A_N), 36'(k > 2));
            chk(36'(ALMOST_FULL_FLAG_PORT_C_N), 36'(k < 7));
            chk(A_DATA_OUT, wd(1));
            @(posedge REF_CLK);
        end
        xfer(1, 36'h0);
        repeat (2) @(negedge REF_CLK);
        chk(A_DATA_OUT, wd(2));
        @(posedge REF_CLK);
        xfer(0, wd(5));
        repeat (5) @(negedge REF_CLK);
        chk(36'(B_DATA), 36'h5);
        @(posedge REF_CLK);
        $display("t_ft end");
    endtask
    initial begin
        t_cfg();
        t_ab();
        t_ft();
        final_report();
    end
endmodule
